/* File: hdl/iecd_defines.svh */
// Constants for the I2C port expander change-detect block.
// Assumes the includer compiles it once; the guard prevents double inclusion.
`ifndef IECD_DEFINES_SVH
`define IECD_DEFINES_SVH

// Fixed upper three slave-address bits of each port group.
`define IECD_GRPA_PREFIX 3'h6
`define IECD_GRPB_PREFIX 3'h5

// Class codes that the strap pins carry into the block.
`define IECD_STRAP_GND 2'h0
`define IECD_STRAP_VCC 2'h1
`define IECD_STRAP_SCL 2'h2
`define IECD_STRAP_SDA 2'h3

// Cycles the synchronised straps settle before they are captured.
`define IECD_STRAP_SETTLE 2'h3

// Reset values of the output groups before the straps are known.
`define IECD_OUTA_RESET 4'hf
`define IECD_OUTB_RESET 8'hff

// Bit-counter value that marks a complete byte.
`define IECD_BYTE_BITS 4'h8
`define IECD_LAST_BIT 4'h7

`endif

/* File: hdl/iecd_pkg.sv */
// Types for the I2C port expander change-detect block.
// Assumes nothing beyond a SystemVerilog compiler.
package iecd_pkg;

    // Serial slave sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RD_DATA,
        ST_RD_ACK,
        ST_WR_DATA,
        ST_WR_ACK
    } iecd_state_e;

    // Two-bit strap class code.
    typedef logic [1:0] iecd_strap_t;

endpackage : iecd_pkg

/* File: hdl/iecd_top.sv */
// I2C slave port expander with latched change detection on four inputs.
// Assumes SCL, SDA, straps and port pins arrive asynchronously; the pad logic builds open-drain wires from the enables.
// How it works
// R1: Snapshot compared with inputs sets change flags.
// R2: Address acknowledge reloads snapshot and clears flags.
// R3: Two-byte read returns port data then flags.
// R4: Longer reads alternate and resample per pair.
// R5: Four-bit mask gates changes onto interrupt.
// R6: Flags set regardless of mask bits.
// R7: Flags stay set until next access.
// R8: No interrupt during read; deferred to STOP.
// R9: No STOP interrupt when change already read.
// R10: Master starts transfers and drives the clock.
// R11: SDA input and open drain; SCL input.
// R12: Frame is START, address, data, STOP.
// R13: START and STOP are SDA edges, SCL high.
// R14: One bit per clock; SDA stable high.
// R15: Ninth clock carries the receiver's low acknowledge.
// R16: Device acks received bytes; master acks sent.
// R17: Eighth address bit: low write, high read.
// R18: Two addresses, prefixes 110 and 101.
// R19: Four-level straps select the low address nibble.
// R20: Grounded strap sets its output nibble low.
// R21: Group access clears flags and interrupt at ack.
// R22: Each written byte updates outputs and mask.
// R23: Port byte carries inputs and output readback.
// R24: Flags and mask align with port bits; interrupt low.
`timescale 1ns/1ps
`include "iecd_defines.svh"

module iecd_top (
    input wire logic CLK, // System clock, 20 MHz.
    input wire logic RST_N, // Asynchronous reset, active low.
    input wire logic SCL_IN, // Serial clock from the bus.
    input wire logic SDA_IN, // Serial data level on the bus.
    output logic SDA_OUT, // Serial data drive value, always low.
    output logic SDA_OE, // High while the block pulls SDA low.
    output logic INT_OE, // High while the open-drain interrupt is pulled low.
    input wire logic [3:0] MONITORED_INPUTS, // Four watched input ports.
    output logic GROUP_A_OUTPUT_0, // Group A output port 0.
    output logic GROUP_A_OUTPUT_1, // Group A output port 1.
    output logic GROUP_A_OUTPUT_6, // Group A output port 6.
    output logic GROUP_A_OUTPUT_7, // Group A output port 7.
    input wire logic [3:0] GROUP_A_READBACK, // Pin levels of outputs 7, 6, 1, 0.
    output logic [7:0] OUTPUT_GROUP_B, // Eight-output group.
    input wire logic [7:0] GROUP_B_READBACK, // Pin levels of the eight-output group.
    input iecd_pkg::iecd_strap_t ADDR_STRAP_LOW, // Class of the low strap pin.
    input iecd_pkg::iecd_strap_t ADDR_STRAP_HIGH // Class of the high strap pin.
);
    import iecd_pkg::*;

    localparam int PIN_W = 22; // Width of the bundle of asynchronous pins.

    // Synchroniser stages; only the second stage is read by logic.
    logic [PIN_W-1:0] sync1_r, sync1_nxt; // First stage.
    logic [PIN_W-1:0] sync2_r, sync2_nxt; // Second stage.
    logic scl_d_r, scl_d_nxt; // Delayed SCL for edge finding.
    logic sda_d_r, sda_d_nxt; // Delayed SDA for edge finding.

    // Sequencer state.
    iecd_state_e state_r, state_nxt; // Serial slave state.
    logic [3:0] cnt_r, cnt_nxt; // Bit counter within a byte.
    logic [7:0] shreg_r, shreg_nxt; // Shift register for both directions.
    logic rd_r, rd_nxt; // Current access is a read.
    logic grpb_r, grpb_nxt; // Current access targets the output group.
    logic pair_r, pair_nxt; // Next read byte is the flag byte.
    logic reading_r, reading_nxt; // Group A read in progress.
    logic sda_oe_r, sda_oe_nxt; // SDA pull-down enable.
    logic sda_out_r; // SDA drive value, held low.

    // Change detection and port state.
    logic [3:0] snap_r, snap_nxt; // Input snapshot.
    logic [3:0] flags_r, flags_nxt; // Sticky change flags.
    logic [3:0] hold_r, hold_nxt; // Flags captured for the second byte.
    logic [3:0] mask_r, mask_nxt; // Interrupt mask.
    logic [3:0] outa_r, outa_nxt; // Group A outputs 7, 6, 1, 0.
    logic [7:0] outb_r, outb_nxt; // Output group B.
    logic int_oe_r, int_oe_nxt; // Interrupt pull-down enable.

    // Strap capture.
    logic [1:0] strap_cnt_r, strap_cnt_nxt; // Settling counter.
    logic strap_done_r, strap_done_nxt; // Straps have been captured.
    logic [3:0] addr_r, addr_nxt; // Low address nibble from the straps.

    // Synchronised views of the pins.
    logic scl_s, sda_s, scl_rise, scl_fall, start_seen, stop_seen; // Bus lines and their events.
    logic [3:0] mon_s, rba_s;
    logic [7:0] rbb_s;
    iecd_strap_t strap_lo_s, strap_hi_s;
    logic [3:0] chg;
    logic [7:0] port_a;
    logic [1:0] hi_bits;
    logic sample;

    assign {scl_s, sda_s, mon_s, rba_s, rbb_s, strap_lo_s, strap_hi_s} = sync2_r;
    // SCL is only ever sampled, never driven. Edges are taken from the second stage and its delay.
    assign scl_rise = scl_s & ~scl_d_r; // R11
    assign scl_fall = ~scl_s & scl_d_r; // R14
    assign start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s; // R13
    assign stop_seen = scl_s & scl_d_r & ~sda_d_r & sda_s; // R13
    // Inputs sit in bits 5..2; the outputs are read back from their pins, not their latches.
    assign port_a = {rba_s[3], rba_s[2], mon_s, rba_s[1], rba_s[0]}; // R23 R24
    assign chg = snap_r ^ mon_s; // R1

    // Synchroniser and edge-delay next values.
    always_comb begin
        sync1_nxt = {SCL_IN, SDA_IN, MONITORED_INPUTS, GROUP_A_READBACK, GROUP_B_READBACK,
                     ADDR_STRAP_LOW, ADDR_STRAP_HIGH};
        sync2_nxt = sync1_r;
        scl_d_nxt = scl_s;
        sda_d_nxt = sda_s;
    end

    // Synchroniser registers; idle bus levels are high.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_r <= '1;
            sync2_r <= '1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            scl_d_r <= scl_d_nxt;
            sda_d_r <= sda_d_nxt;
        end
    end

    // Strap decode; the straps are caught after release because a reset flop may only take constants.
    always_comb begin
        case (strap_hi_s)
            `IECD_STRAP_SCL: hi_bits = 2'h0; // R19
            `IECD_STRAP_SDA: hi_bits = 2'h1;
            `IECD_STRAP_GND: hi_bits = 2'h2;
            default: hi_bits = 2'h3;
        endcase
        strap_cnt_nxt = strap_cnt_r;
        strap_done_nxt = strap_done_r;
        addr_nxt = addr_r;
        if (!strap_done_r) begin
            strap_cnt_nxt = 2'(strap_cnt_r + 2'h1);
            if (strap_cnt_r == `IECD_STRAP_SETTLE) begin
                strap_done_nxt = 1'b1;
                addr_nxt = {hi_bits, strap_lo_s}; // R19
            end
        end
    end

    // Sequencer, change detection, ports and interrupt next values.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shreg_nxt = shreg_r;
        rd_nxt = rd_r;
        grpb_nxt = grpb_r;
        pair_nxt = pair_r;
        reading_nxt = reading_r;
        sda_oe_nxt = sda_oe_r;
        outa_nxt = outa_r;
        outb_nxt = outb_r;
        mask_nxt = mask_r;
        sample = ~strap_done_r; // R1 The synchroniser resets high, so track the pins until settled.

        // Power-up defaults follow the straps once they are known.
        if (!strap_done_r && strap_cnt_r == `IECD_STRAP_SETTLE) begin
            outb_nxt = {(strap_hi_s == `IECD_STRAP_GND) ? 4'h0 : 4'hf,
                        (strap_lo_s == `IECD_STRAP_GND) ? 4'h0 : 4'hf}; // R20
            outa_nxt = {(strap_hi_s == `IECD_STRAP_GND) ? 2'h0 : 2'h3,
                        (strap_lo_s == `IECD_STRAP_GND) ? 2'h0 : 2'h3};
        end

        // START and STOP override any state, so a broken transfer always recovers.
        if (start_seen) begin
            state_nxt = ST_ADDR; // R12
            cnt_nxt = 4'h0;
            sda_oe_nxt = 1'b0;
            reading_nxt = 1'b0;
        end else if (stop_seen) begin
            state_nxt = ST_IDLE; // R12
            sda_oe_nxt = 1'b0;
            reading_nxt = 1'b0; // R8
        end else begin
            case (state_r)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shreg_nxt = {shreg_r[6:0], sda_s}; // R14
                        cnt_nxt = 4'(cnt_r + 4'h1);
                    end
                    if (scl_fall && cnt_r == `IECD_BYTE_BITS) begin
                        cnt_nxt = 4'h0;
                        rd_nxt = shreg_r[0]; // R17
                        grpb_nxt = (shreg_r[7:5] == `IECD_GRPB_PREFIX);
                        if (shreg_r[4:1] == addr_r && (shreg_r[7:5] == `IECD_GRPA_PREFIX ||
                            shreg_r[7:5] == `IECD_GRPB_PREFIX)) begin // R18
                            state_nxt = ST_ADDR_ACK;
                            sda_oe_nxt = 1'b1; // R15 R16
                        end else begin
                            state_nxt = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    // The snapshot is taken inside the acknowledge clock, so a master that never clocks it leaves all alone.
                    if (scl_rise) begin
                        sample = 1'b1; // R2 R21
                        pair_nxt = 1'b1;
                        shreg_nxt = grpb_r ? rbb_s : port_a; // R3
                        reading_nxt = rd_r & ~grpb_r; // R8
                    end
                    if (scl_fall) begin
                        state_nxt = rd_r ? ST_RD_DATA : ST_WR_DATA;
                        sda_oe_nxt = rd_r & ~shreg_r[7];
                    end
                end
                ST_RD_DATA: begin
                    if (scl_fall) begin
                        if (cnt_r == `IECD_LAST_BIT) begin
                            cnt_nxt = 4'h0;
                            state_nxt = ST_RD_ACK;
                            sda_oe_nxt = 1'b0; // R16
                        end else begin
                            cnt_nxt = 4'(cnt_r + 4'h1);
                            shreg_nxt = {shreg_r[6:0], 1'b0};
                            sda_oe_nxt = ~shreg_r[6]; // R14
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_nxt = ST_IDLE; // R16
                        end else if (grpb_r) begin
                            shreg_nxt = rbb_s;
                        end else if (pair_r) begin
                            shreg_nxt = {2'h0, hold_r, 2'h0}; // R3 R24
                            pair_nxt = 1'b0;
                        end else begin
                            shreg_nxt = port_a; // R4
                            sample = 1'b1; // R4
                            pair_nxt = 1'b1;
                        end
                    end
                    if (scl_fall) begin
                        state_nxt = ST_RD_DATA;
                        sda_oe_nxt = ~shreg_r[7];
                    end
                end
                ST_WR_DATA: begin
                    if (scl_rise) begin
                        shreg_nxt = {shreg_r[6:0], sda_s};
                        cnt_nxt = 4'(cnt_r + 4'h1);
                    end
                    if (scl_fall && cnt_r == `IECD_BYTE_BITS) begin
                        cnt_nxt = 4'h0;
                        state_nxt = ST_WR_ACK;
                        sda_oe_nxt = 1'b1; // R16
                    end
                end
                ST_WR_ACK: begin
                    if (scl_rise) begin
                        if (grpb_r) begin
                            outb_nxt = shreg_r;
                        end else begin
                            outa_nxt = {shreg_r[7], shreg_r[6], shreg_r[1], shreg_r[0]}; // R22
                            mask_nxt = shreg_r[5:2]; // R22 R24
                        end
                    end
                    if (scl_fall) begin
                        state_nxt = ST_WR_DATA;
                        sda_oe_nxt = 1'b0;
                    end
                end
                default: sda_oe_nxt = 1'b0; // ST_IDLE and the one unused code keep the data line released.
            endcase
        end

        // Flags are sticky and ignore the mask; a sample clears them while the held copy keeps the old ones.
        snap_nxt = sample ? mon_s : snap_r;
        hold_nxt = sample ? (flags_r | chg) : hold_r; // R3
        flags_nxt = sample ? 4'h0 : (flags_r | chg); // R1 R6 R7

        // A resample inside the read clears what was sent, so STOP raises only unread changes.
        int_oe_nxt = (|(flags_nxt & mask_r)) & ~reading_nxt; // R5 R8 R9 R24
    end

    // Sequencer and port registers.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            shreg_r <= 8'h00;
            rd_r <= 1'b0;
            grpb_r <= 1'b0;
            pair_r <= 1'b0;
            reading_r <= 1'b0;
            sda_oe_r <= 1'b0;
            sda_out_r <= 1'b0;
            snap_r <= 4'h0;
            flags_r <= 4'h0;
            hold_r <= 4'h0;
            mask_r <= 4'h0;
            outa_r <= `IECD_OUTA_RESET;
            outb_r <= `IECD_OUTB_RESET;
            int_oe_r <= 1'b0;
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
            addr_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shreg_r <= shreg_nxt;
            rd_r <= rd_nxt;
            grpb_r <= grpb_nxt;
            pair_r <= pair_nxt;
            reading_r <= reading_nxt;
            sda_oe_r <= sda_oe_nxt;
            sda_out_r <= 1'b0;
            snap_r <= snap_nxt;
            flags_r <= flags_nxt;
            hold_r <= hold_nxt;
            mask_r <= mask_nxt;
            outa_r <= outa_nxt;
            outb_r <= outb_nxt;
            int_oe_r <= int_oe_nxt;
            strap_cnt_r <= strap_cnt_nxt;
            strap_done_r <= strap_done_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Every output is a flop.
    assign SDA_OUT = sda_out_r;
    assign SDA_OE = sda_oe_r; // R11
    assign INT_OE = int_oe_r;
    assign {GROUP_A_OUTPUT_7, GROUP_A_OUTPUT_6, GROUP_A_OUTPUT_1, GROUP_A_OUTPUT_0} = outa_r;
    assign OUTPUT_GROUP_B = outb_r;

endmodule : iecd_top

/* File: verification/iecd_monitor.sv */
// Checker for the expander's serial pins, output groups and interrupt.
// Sees only the top module's ports and is bound to it below.
`timescale 1ns/1ps
module iecd_monitor (
    input wire logic CLK, // System clock.
    input wire logic RST_N, // Reset, active low.
    input wire logic SCL_IN, // Bus clock level.
    input wire logic SDA_IN, // Bus data level.
    input wire logic SDA_OUT, // Data drive value.
    input wire logic SDA_OE, // Data pull enable.
    input wire logic INT_OE, // Interrupt pull enable.
    input wire logic GROUP_A_OUTPUT_0, // Group A port 0.
    input wire logic GROUP_A_OUTPUT_1, // Group A port 1.
    input wire logic GROUP_A_OUTPUT_6, // Group A port 6.
    input wire logic GROUP_A_OUTPUT_7, // Group A port 7.
    input wire logic [7:0] OUTPUT_GROUP_B // Group B ports.
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // The data pin may only ever be pulled low.
    a_sda_drive_low:
        assert property (SDA_OUT == 1'b0) else $error("data driven high");
    // Data may only move while the bus clock is low.
    a_oe_scl_low:
        assert property ($changed(SDA_OE) |-> !$past(SCL_IN, 2)) else $error("data moved in clock high");
    // A pulled bit stands for a whole clock period.
    a_oe_min_width:
        assert property ($rose(SDA_OE) |=> SDA_OE [*6]) else $error("data pull too short");
    // Group B only updates at strap capture or at an acknowledge clock high.
    a_grpb_at_ack:
        assert property ($changed(OUTPUT_GROUP_B) |-> $past(SCL_IN, 2)) else $error("group b moved off ack");
    // Group A only updates at strap capture or at an acknowledge clock high.
    a_grpa_at_ack:
        assert property ($changed({GROUP_A_OUTPUT_7, GROUP_A_OUTPUT_6, GROUP_A_OUTPUT_1, GROUP_A_OUTPUT_0})
            |-> $past(SCL_IN, 2)) else $error("group a moved off ack");
    // The interrupt is cleared only in an acknowledge clock high.
    a_int_clear_ack:
        assert property ($fell(INT_OE) |-> $past(SCL_IN, 2)) else $error("interrupt cleared off ack");
    // After a stop the device keeps the line released.
    a_stop_release:
        assert property ($rose(SDA_IN) && SCL_IN && $past(SCL_IN) |=> !SDA_OE [*8]) else $error("pull after stop");
    // After a start no acknowledge can come before the address.
    a_start_quiet:
        assert property ($fell(SDA_IN) && SCL_IN && $past(SCL_IN) |-> !SDA_OE [*8]) else $error("pull after start");
endmodule : iecd_monitor

bind iecd_top iecd_monitor mon (.CLK(CLK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .INT_OE(INT_OE), .GROUP_A_OUTPUT_0(GROUP_A_OUTPUT_0), .GROUP_A_OUTPUT_1(GROUP_A_OUTPUT_1),
    .GROUP_A_OUTPUT_6(GROUP_A_OUTPUT_6), .GROUP_A_OUTPUT_7(GROUP_A_OUTPUT_7), .OUTPUT_GROUP_B(OUTPUT_GROUP_B));

/* File: verification/iecd_master.sv */
// Bus master model that clocks the expander's serial link at 400 ns a bit.
// Assumes a pull-up on data: the line is low while any party pulls it.
`timescale 1ns/1ps
module iecd_master (
    output logic scl, // Serial clock, idle high.
    output logic sda_low, // High while this master pulls data low.
    input wire logic sda // Resolved data line.
);
    // Both lines idle high.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One pulse: data set mid-low, sampled mid-high, never moved while high.
    task automatic bit_x(input logic b, output logic r);
        #100 sda_low = !b;
        #100 scl = 1'b1;
        #100 r = sda;
        #100 scl = 1'b0;
    endtask : bit_x
    // Start: data falls while the clock is high.
    task automatic start;
        sda_low = 1'b1;
        #200 scl = 1'b0;
    endtask : start
    // Stop: data rises while the clock is high.
    task automatic stop;
        #100 sda_low = 1'b1;
        #100 scl = 1'b1;
        #100 sda_low = 1'b0;
        #100;
    endtask : stop
    // Byte out, first bit most significant; the ninth pulse returns the ack.
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : wbyte
    // Byte in; the master acks all but the last byte it wants.
    task automatic rbyte(input logic give_ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(!give_ack, r);
    endtask : rbyte
endmodule : iecd_master

/* File: verification/tb_top.sv */
// Self-checking bench for the port expander with its bus master model.
// Assumes straps low = supply, high = ground, so the address nibble is 4'h9.
`timescale 1ns/1ps
`include "iecd_defines.svh"
module tb_top;
    import iecd_pkg::*;
    localparam logic [6:0] ADDR_A = {`IECD_GRPA_PREFIX, 4'h9}; // Group A address.
    localparam logic [6:0] ADDR_B = {`IECD_GRPB_PREFIX, 4'h9}; // Group B address.
    logic clk, rst_n, scl, sda_low, sda_oe, sda_out, int_oe, o0, o1, o6, o7, ack; // Pins.
    logic [3:0] mon_in; // Watched inputs.
    logic [7:0] grp_b, d; // Group B outputs and read data.
    int n_errors = 0, check_count = 0, cycles = 0; // Counters.
    wire sda = !(sda_low | sda_oe); // Pulled-up data line.
    iecd_master m (.scl(scl), .sda_low(sda_low), .sda(sda));
    iecd_top uut (.CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .INT_OE(int_oe), .MONITORED_INPUTS(mon_in), .GROUP_A_OUTPUT_0(o0), .GROUP_A_OUTPUT_1(o1),
        .GROUP_A_OUTPUT_6(o6), .GROUP_A_OUTPUT_7(o7), .GROUP_A_READBACK({o7, o6, o1, o0}),
        .OUTPUT_GROUP_B(grp_b), .GROUP_B_READBACK(grp_b), .ADDR_STRAP_LOW(`IECD_STRAP_VCC),
        .ADDR_STRAP_HIGH(`IECD_STRAP_GND));
    // 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // The whole run needs about 1600 cycles; 20000 means a hang.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Lets synchronisers and flags settle, then realigns just after an edge.
    task automatic settle;
        repeat (10) @(posedge clk);
        #1;
    endtask : settle
    task automatic addr(input logic [6:0] a, input logic rd, input logic e_ack);
        m.start();
        m.wbyte({a, rd}, ack);
        chk("address ack", {7'h0, e_ack}, {7'h0, ack});
        if (!e_ack) m.stop();
    endtask : addr
    task automatic chk_int(input logic e);
        chk("interrupt", {7'h0, e}, {7'h0, int_oe});
    endtask : chk_int
    // Straps pick the starting levels of both output groups; reset must leave no stale change flags.
    task automatic t_power_up;
        chk("group b", 8'h0f, grp_b);
        chk("group a", 8'h03, {4'h0, o7, o6, o1, o0});
        addr(ADDR_A, 1'b1, 1'b1);
        m.rbyte(1'b1, d);
        chk("port byte", 8'h03, d);
        m.rbyte(1'b0, d);
        chk("flag byte", 8'h00, d);
        m.stop();
    endtask : t_power_up
    // Foreign addresses are ignored; group B writes and reads back.
    task automatic t_addressing;
        addr({3'h7, 4'h9}, 1'b0, 1'b0);
        addr({`IECD_GRPA_PREFIX, 4'h8}, 1'b0, 1'b0);
        addr(ADDR_B, 1'b0, 1'b1);
        m.wbyte(8'ha5, ack);
        chk("data ack", 8'h01, {7'h0, ack});
        m.stop();
        chk("group b", 8'ha5, grp_b);
        addr(ADDR_B, 1'b1, 1'b1);
        m.rbyte(1'b0, d);
        m.stop();
        chk("group b read", 8'ha5, d);
    endtask : t_addressing
    // Each byte updates ports and mask; flags ignore the mask and stick.
    task automatic t_mask;
        addr(ADDR_A, 1'b0, 1'b1);
        m.wbyte(8'h43, ack);
        chk("group a", 8'h07, {4'h0, o7, o6, o1, o0});
        m.wbyte(8'h87, ack);
        m.stop();
        chk("group a", 8'h0b, {4'h0, o7, o6, o1, o0});
        mon_in = 4'h2;
        settle();
        chk_int(1'b0);
        mon_in = 4'h3;
        settle();
        chk_int(1'b1);
        mon_in = 4'h2;
        settle();
        chk_int(1'b1);
    endtask : t_mask
    // Two-byte read: old flags second; a change mid-read waits for stop.
    task automatic t_two_byte;
        addr(ADDR_A, 1'b1, 1'b1);
        chk_int(1'b0);
        m.rbyte(1'b1, d);
        chk("port byte", 8'h8b, d);
        mon_in = 4'h3;
        m.rbyte(1'b0, d);
        chk("flag byte", 8'h0c, d);
        settle();
        chk_int(1'b0);
        m.stop();
        settle();
        chk_int(1'b1);
    endtask : t_two_byte
    // Long read resamples per pair; a change already read gives no interrupt.
    task automatic t_long_read;
        addr(ADDR_A, 1'b1, 1'b1);
        m.rbyte(1'b1, d);
        chk("port byte", 8'h8f, d);
        mon_in = 4'h6;
        m.rbyte(1'b1, d);
        chk("flag byte", 8'h04, d);
        m.rbyte(1'b1, d);
        chk("port byte", 8'h9b, d);
        m.rbyte(1'b0, d);
        chk("flag byte", 8'h14, d);
        m.stop();
        settle();
        chk_int(1'b0);
    endtask : t_long_read
    // Reset, then the scenarios in order.
    initial begin
        rst_n = 1'b0;
        mon_in = 4'h0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        t_power_up();
        t_addressing();
        t_mask();
        t_two_byte();
        t_long_read();
        conclude();
    end
endmodule : tb_top
